/* File: design/lsr_top.sv */
// Top of the LIN status readout: registers, pending query and response contents.
`timescale 1ns/1ps
module lsr_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [lsr_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	input wire logic i_id_valid,
	input wire logic [7:0] i_id,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	input wire logic i_tx_ready,
	output logic o_flag_clear,
	input wire logic i_end_switch_state,
	input wire logic [15:0] i_actual_position,
	input wire logic [15:0] i_target_position,
	input wire logic [10:0] i_secondary_position,
	input wire logic i_supply_reset_flag,
	input wire logic i_step_loss_flag,
	input wire logic i_electrical_defect_flag,
	input wire logic i_undervoltage_flag,
	input wire logic i_thermal_shutdown_flag,
	input wire logic i_thermal_warning_flag,
	input wire logic [1:0] i_temp_info,
	input wire logic [3:0] i_run_current,
	input wire logic [3:0] i_hold_current,
	input wire logic [3:0] i_max_velocity,
	input wire logic [3:0] i_min_velocity,
	input wire logic i_acceleration_shape,
	input wire logic [1:0] i_step_resolution,
	input wire logic i_shaft,
	input wire logic [3:0] i_acceleration,
	input wire logic [2:0] i_motion,
	input wire logic i_overcurrent_coil_x,
	input wire logic i_overcurrent_coil_y,
	input wire logic i_charge_pump_failure,
	input wire logic i_lin_timeout_error,
	input wire logic i_lin_data_error,
	input wire logic i_lin_header_error,
	input wire logic i_lin_bit_error
);
	import lsr_pkg::*;

	typedef struct packed {
		logic [6:0] node;
		logic [4:0] dyn;
		lsr_pend_t pend;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic [7:0] rdata;
		logic start;
		logic [63:0] bytes;
		logic clr;
	} lsr_top_st_t;

	lsr_top_st_t st_ff;
	lsr_top_st_t nxt_st;
	logic rsp_hdr;
	logic [7:0] flag_byte;

	lsr_link_if lnk ();

	// Decodes the preparing frames addressed to this node.
	lsr_rx_decoder u_rx (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_id_valid(i_id_valid),
		.i_id(i_id),
		.i_rx_valid(i_rx_valid),
		.i_rx_byte(i_rx_byte),
		.i_node_addr(st_ff.node),
		.i_dyn_id(st_ff.dyn),
		.lnk(lnk.rx)
	);

	// Sends the response bytes; any new header cuts a running response short.
	lsr_tx_frame u_tx (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_abort(i_id_valid),
		.i_tx_ready(i_tx_ready),
		.o_tx_valid(o_tx_valid),
		.o_tx_byte(o_tx_byte),
		.lnk(lnk.tx)
	);

	// A response header on the fixed indirect identifier asks for pending data.
	assign rsp_hdr = i_id_valid && i_id == PID_DIAG_RSP;

	// Status flag byte shared by the position and first full status responses.
	assign flag_byte = {i_supply_reset_flag, i_step_loss_flag, i_electrical_defect_flag,
		i_undervoltage_flag, i_thermal_shutdown_flag, i_thermal_warning_flag, i_temp_info};

	// Register access, interrupt bookkeeping and the pending query sequence.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.start = 1'b0;
		nxt_st.clr = 1'b0;
		nxt_st.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				REG_NODE_ADDR: nxt_st.rdata = {1'b0, st_ff.node};
				REG_DYN_ID: nxt_st.rdata = {3'h0, st_ff.dyn};
				REG_STATE: nxt_st.rdata = {5'h00, st_ff.pend, lnk.tx_busy};
				REG_IRQ_STAT: nxt_st.rdata = {5'h00, st_ff.irq_st};
				REG_IRQ_MASK: nxt_st.rdata = {5'h00, st_ff.irq_mask};
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		if (i_wr) begin
			case (i_addr)
				REG_NODE_ADDR: nxt_st.node = i_wdata[6:0];
				REG_DYN_ID: nxt_st.dyn = i_wdata[4:0];
				REG_IRQ_STAT: nxt_st.irq_st = st_ff.irq_st & ~i_wdata[IRQ_W-1:0];
				REG_IRQ_MASK: nxt_st.irq_mask = i_wdata[IRQ_W-1:0];
				default: nxt_st.node = st_ff.node;
			endcase
		end
		// Hardware events come after the clear so that a set in the same cycle wins.
		if (lnk.tx_done) begin
			nxt_st.irq_st[IRQ_SENT] = 1'b1;
			case (st_ff.pend)
				PEND_FS1: begin
					nxt_st.pend = PEND_FS2;
					nxt_st.clr = 1'b1;
				end
				default: nxt_st.pend = PEND_NONE;
			endcase
		end
		if (lnk.cmd_valid) begin
			nxt_st.irq_st[IRQ_CMD] = 1'b1;
			nxt_st.pend = lnk.cmd_full ? PEND_FS1 : PEND_POS;
		end
		if (lnk.cmd_bad_csum) begin
			nxt_st.irq_st[IRQ_CSUM] = 1'b1;
		end
		if (rsp_hdr && st_ff.pend != PEND_NONE) begin
			nxt_st.start = 1'b1;
			case (st_ff.pend)
				PEND_POS: begin
					nxt_st.bytes = {i_end_switch_state, st_ff.node, i_actual_position,
						flag_byte, {4{FILL_BYTE}}};
				end
				PEND_FS1: begin
					nxt_st.bytes = {1'b1, st_ff.node, i_run_current, i_hold_current,
						i_max_velocity, i_min_velocity, i_acceleration_shape,
						i_step_resolution, i_shaft, i_acceleration, flag_byte,
						i_motion, i_end_switch_state, i_overcurrent_coil_x,
						i_overcurrent_coil_y, 1'b1, i_charge_pump_failure, 4'hF,
						i_lin_timeout_error, i_lin_data_error, i_lin_header_error,
						i_lin_bit_error, FILL_BYTE};
				end
				default: begin
					nxt_st.bytes = {1'b1, st_ff.node, i_actual_position,
						i_target_position, i_secondary_position[7:0], 5'h1F,
						i_secondary_position[10:8], FILL_BYTE};
				end
			endcase
		end
	end

	// Registers the control state; the node address and identifier start at their defaults.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.node <= NODE_ADDR_RST;
			st_ff.dyn <= DYN_ID_RST;
			st_ff.irq_st <= IRQ_RST;
			st_ff.irq_mask <= IRQ_RST;
			st_ff.pend <= PEND_NONE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lnk.tx_start = st_ff.start;
	assign lnk.tx_bytes = st_ff.bytes;
	assign o_rdata = st_ff.rdata;
	assign o_flag_clear = st_ff.clr;
	// The interrupt is high while any unmasked status bit is set.
	assign o_irq = |(st_ff.irq_st & st_ff.irq_mask);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_pos_rsp;
		rsp_hdr && st_ff.pend == PEND_POS |=> st_ff.start
			&& st_ff.bytes[55:40] == $past(i_actual_position)
			&& st_ff.bytes[39:32] == $past(flag_byte) && st_ff.bytes[31:0] == 32'hFFFFFFFF;
	endproperty
	a_pos_rsp: assert property (p_pos_rsp) else $error("position response wrong");

	property p_flag_clear;
		lnk.tx_done && st_ff.pend == PEND_FS1 && !lnk.cmd_valid |=> o_flag_clear ##1 !o_flag_clear;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

	property p_fs_seq;
		lnk.tx_done && st_ff.pend == PEND_FS1 && !lnk.cmd_valid |=> st_ff.pend == PEND_FS2;
	endproperty
	a_fs_seq: assert property (p_fs_seq) else $error("second part not armed");

	property p_fs1_params;
		rsp_hdr && st_ff.pend == PEND_FS1 |=> st_ff.start && st_ff.bytes[63] == 1'b1
			&& st_ff.bytes[55:48] == {$past(i_run_current), $past(i_hold_current)}
			&& st_ff.bytes[35:32] == $past(i_acceleration);
	endproperty
	a_fs1_params: assert property (p_fs1_params) else $error("first part parameters wrong");

	property p_fs1_flags;
		rsp_hdr && st_ff.pend == PEND_FS1 |=> st_ff.bytes[31:24] == $past(flag_byte)
			&& st_ff.bytes[17] == 1'b1 && st_ff.bytes[15:12] == 4'hF
			&& st_ff.bytes[7:0] == 8'hFF && st_ff.bytes[23:21] == $past(i_motion);
	endproperty
	a_fs1_flags: assert property (p_fs1_flags) else $error("first part flags wrong");

	property p_fs2_pos;
		rsp_hdr && st_ff.pend == PEND_FS2 |=> st_ff.start
			&& st_ff.bytes[39:24] == $past(i_target_position)
			&& st_ff.bytes[15:11] == 5'h1F && st_ff.bytes[10:8] == $past(i_secondary_position[10:8]);
	endproperty
	a_fs2_pos: assert property (p_fs2_pos) else $error("second part positions wrong");

	// Data is zero without a read.
	property p_rd_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");

	// A set beats a clear in the same cycle.
	property p_csum_irq;
		lnk.cmd_bad_csum |=> st_ff.irq_st[IRQ_CSUM];
	endproperty
	a_csum_irq: assert property (p_csum_irq) else $error("checksum event lost");

	// A taken command is flagged and pending.
	property p_cmd_take;
		lnk.cmd_valid |=> st_ff.irq_st[IRQ_CMD]
			&& st_ff.pend == ($past(lnk.cmd_full) ? PEND_FS1 : PEND_POS);
	endproperty
	a_cmd_take: assert property (p_cmd_take) else $error("command not taken");

	// A sent frame sets its bit.
	property p_sent_irq;
		lnk.tx_done |=> st_ff.irq_st[IRQ_SENT];
	endproperty
	a_sent_irq: assert property (p_sent_irq) else $error("sent event lost");

	// No answer is sent unqueried.
	property p_no_answer;
		rsp_hdr && st_ff.pend == PEND_NONE |=> !st_ff.start;
	endproperty
	a_no_answer: assert property (p_no_answer) else $error("answer without query");

	// The position answer leads with switch and address.
	property p_pos_head;
		rsp_hdr && st_ff.pend == PEND_POS
			|=> st_ff.bytes[63:56] == {$past(i_end_switch_state), $past(st_ff.node)};
	endproperty
	a_pos_head: assert property (p_pos_head) else $error("position head wrong");

	// A sent position answer retires and clears no flag.
	property p_pos_done;
		lnk.tx_done && st_ff.pend == PEND_POS && !lnk.cmd_valid
			|=> st_ff.pend == PEND_NONE && !o_flag_clear;
	endproperty
	a_pos_done: assert property (p_pos_done) else $error("position not retired");

	// The second part leads with address and position.
	property p_fs2_head;
		rsp_hdr && st_ff.pend == PEND_FS2 |=> st_ff.bytes[7:0] == 8'hFF
			&& st_ff.bytes[63:40] == {1'b1, $past(st_ff.node), $past(i_actual_position)};
	endproperty
	a_fs2_head: assert property (p_fs2_head) else $error("second part head wrong");

	// A sent second part retires the query.
	property p_fs2_done;
		lnk.tx_done && st_ff.pend == PEND_FS2 && !lnk.cmd_valid
			|=> st_ff.pend == PEND_NONE;
	endproperty
	a_fs2_done: assert property (p_fs2_done) else $error("second part not retired");

	// Motion settings fill bytes 3 and 4.
	property p_fs1_motion;
		rsp_hdr && st_ff.pend == PEND_FS1
			|=> st_ff.bytes[47:36] == {$past(i_max_velocity), $past(i_min_velocity),
			$past(i_acceleration_shape), $past(i_step_resolution), $past(i_shaft)};
	endproperty
	a_fs1_motion: assert property (p_fs1_motion) else $error("first part motion wrong");

	// Pump and link errors fill bytes 6 and 7.
	property p_fs1_errs;
		rsp_hdr && st_ff.pend == PEND_FS1 |=> st_ff.bytes[16] == $past(i_charge_pump_failure)
			&& st_ff.bytes[11:8] == {$past(i_lin_timeout_error), $past(i_lin_data_error),
			$past(i_lin_header_error), $past(i_lin_bit_error)};
	endproperty
	a_fs1_errs: assert property (p_fs1_errs) else $error("first part errors wrong");
endmodule

/* File: design/lsr_pkg.sv */
// Package of constants, types and helpers for the LIN status readout block.
// How it works
// - Position response carries switch, position, flag byte.
// - Identifier top bits are LIN parity bits.
// - Full status query clears the latched fault flags.
// - Full status answers twice on identifier 0x3D.
// - First full status response packs motion parameters.
// - First response continues with flags and errors.
// - Second response packs actual, target, secondary positions.
package lsr_pkg;
	localparam logic [7:0] PID_DIAG_REQ = 8'h3C;
	localparam logic [7:0] PID_DIAG_RSP = 8'h7D;
	localparam logic [7:0] APP_CMD_BYTE = 8'h80;
	localparam logic [6:0] CMD_POSITION = 7'h00;
	localparam logic [6:0] CMD_FULL_STATUS = 7'h01;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [3:0] LONG_DATA_LEN = 4'h8;
	localparam logic [3:0] SHORT_DATA_LEN = 4'h2;
	localparam logic [3:0] RSP_DATA_LEN = 4'h8;
	localparam int ADDR_W = 3;
	localparam logic [2:0] REG_NODE_ADDR = 3'h0;
	localparam logic [2:0] REG_DYN_ID = 3'h1;
	localparam logic [2:0] REG_STATE = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK = 3'h4;
	localparam logic [6:0] NODE_ADDR_RST = 7'h00;
	localparam logic [4:0] DYN_ID_RST = 5'h00;
	localparam int IRQ_W = 3;
	localparam int IRQ_CMD = 0;
	localparam int IRQ_SENT = 1;
	localparam int IRQ_CSUM = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	typedef enum logic [1:0] {PEND_NONE, PEND_POS, PEND_FS1, PEND_FS2} lsr_pend_t;

	// Adds a byte to a running sum, folding the carry back in.
	function automatic logic [7:0] lsr_csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	// Builds a protected identifier from its six identifier bits.
	function automatic logic [7:0] lsr_pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction
endpackage

/* File: design/lsr_link_if.sv */
// Interface joining the decoder, the response sender and the control logic.
`timescale 1ns/1ps
interface lsr_link_if;
	logic cmd_valid;
	logic cmd_full;
	logic cmd_bad_csum;
	logic tx_start;
	logic [63:0] tx_bytes;
	logic tx_done;
	logic tx_busy;
	modport rx (output cmd_valid, output cmd_full, output cmd_bad_csum);
	modport tx (input tx_start, input tx_bytes, output tx_done, output tx_busy);
	modport ctl (input cmd_valid, input cmd_full, input cmd_bad_csum, input tx_done,
		input tx_busy, output tx_start, output tx_bytes);
endinterface

/* File: design/lsr_rx_decoder.sv */
// Decoder of short and long preparing frames sent by the master.
`timescale 1ns/1ps
module lsr_rx_decoder (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_id_valid,
	input wire logic [7:0] i_id,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic [6:0] i_node_addr,
	input wire logic [4:0] i_dyn_id,
	lsr_link_if.rx lnk
);
	import lsr_pkg::*;

	typedef enum logic {R_IDLE, R_DATA} lsr_rx_state_t;
	typedef struct packed {
		lsr_rx_state_t state;
		logic long_fr;
		logic [3:0] cnt;
		logic [7:0] sum;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic cmd_valid;
		logic cmd_full;
		logic bad;
	} lsr_rx_st_t;

	lsr_rx_st_t st_ff;
	lsr_rx_st_t nxt_st;
	logic last;

	assign last = st_ff.cnt == (st_ff.long_fr ? LONG_DATA_LEN : SHORT_DATA_LEN);

	// Collects the data bytes, checks the checksum and decodes command and address.
	always_comb begin
		logic ok;
		logic [6:0] cmd;
		logic [6:0] ad;
		ok = 1'b0;
		cmd = 7'h00;
		ad = 7'h00;
		nxt_st = st_ff;
		nxt_st.cmd_valid = 1'b0;
		nxt_st.cmd_full = 1'b0;
		nxt_st.bad = 1'b0;
		if (i_id_valid) begin
			nxt_st.state = R_IDLE;
			nxt_st.cnt = 4'h0;
			nxt_st.sum = 8'h00;
			if (i_id == PID_DIAG_REQ) begin
				nxt_st.state = R_DATA;
				nxt_st.long_fr = 1'b1;
			end else if (i_id == lsr_pid({1'b0, i_dyn_id})) begin
				nxt_st.state = R_DATA;
				nxt_st.long_fr = 1'b0;
			end
		end else if (i_rx_valid && st_ff.state == R_DATA) begin
			if (!last) begin
				nxt_st.sum = lsr_csum_add(st_ff.sum, i_rx_byte);
				nxt_st.cnt = st_ff.cnt + 4'h1;
				case (st_ff.cnt)
					4'h0: nxt_st.b1 = i_rx_byte;
					4'h1: nxt_st.b2 = i_rx_byte;
					4'h2: nxt_st.b3 = i_rx_byte;
					default: nxt_st.b3 = st_ff.b3;
				endcase
			end else begin
				nxt_st.state = R_IDLE;
				if (~st_ff.sum != i_rx_byte) begin
					nxt_st.bad = 1'b1;
				end else begin
					if (st_ff.long_fr) begin
						ok = st_ff.b1 == APP_CMD_BYTE && st_ff.b2[7] && st_ff.b3[7];
						cmd = st_ff.b2[6:0];
						ad = st_ff.b3[6:0];
					end else begin
						ok = st_ff.b1[7] && st_ff.b2[7];
						cmd = st_ff.b1[6:0];
						ad = st_ff.b2[6:0];
					end
					if (ok && ad == i_node_addr &&
						(cmd == CMD_POSITION || cmd == CMD_FULL_STATUS)) begin
						nxt_st.cmd_valid = 1'b1;
						nxt_st.cmd_full = cmd == CMD_FULL_STATUS;
					end
				end
			end
		end
	end

	// Registers the decoder state.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign lnk.cmd_valid = st_ff.cmd_valid;
	assign lnk.cmd_full = st_ff.cmd_full;
	assign lnk.cmd_bad_csum = st_ff.bad;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_pid_reject;
		i_id_valid && i_id[5:0] == {1'b0, i_dyn_id} && i_id != lsr_pid({1'b0, i_dyn_id})
			&& i_id != PID_DIAG_REQ |=> st_ff.state == R_IDLE;
	endproperty
	a_pid_reject: assert property (p_pid_reject) else $error("bad parity id accepted");

	property p_rx_csum;
		!i_id_valid && i_rx_valid && st_ff.state == R_DATA && last && ~st_ff.sum != i_rx_byte
			|=> st_ff.bad && !st_ff.cmd_valid;
	endproperty
	a_rx_csum: assert property (p_rx_csum) else $error("bad checksum accepted");
endmodule

/* File: design/lsr_tx_frame.sv */
// Sender of an eight byte response followed by its checksum.
`timescale 1ns/1ps
module lsr_tx_frame (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_abort,
	input wire logic i_tx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	lsr_link_if.tx lnk
);
	import lsr_pkg::*;

	typedef struct packed {
		logic busy;
		logic [3:0] idx;
		logic [63:0] shreg;
		logic [7:0] sum;
		logic [7:0] byte_out;
		logic done;
	} lsr_tx_st_t;

	lsr_tx_st_t st_ff;
	lsr_tx_st_t nxt_st;

	// Shifts the bytes out and appends the checksum; a new header aborts a frame.
	always_comb begin
		logic [7:0] s;
		s = lsr_csum_add(st_ff.sum, st_ff.byte_out);
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (i_abort) begin
			nxt_st.busy = 1'b0;
		end
		if (lnk.tx_start) begin
			nxt_st.busy = 1'b1;
			nxt_st.idx = 4'h0;
			nxt_st.sum = 8'h00;
			nxt_st.shreg = lnk.tx_bytes;
			nxt_st.byte_out = lnk.tx_bytes[63:56];
		end else if (st_ff.busy && i_tx_ready && !i_abort) begin
			if (st_ff.idx == RSP_DATA_LEN) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.sum = s;
				nxt_st.idx = st_ff.idx + 4'h1;
				nxt_st.shreg = {st_ff.shreg[55:0], 8'h00};
				if (st_ff.idx == RSP_DATA_LEN - 4'h1) begin
					nxt_st.byte_out = ~s;
				end else begin
					nxt_st.byte_out = st_ff.shreg[55:48];
				end
			end
		end
	end

	// Registers the sender state.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_tx_valid = st_ff.busy;
	assign o_tx_byte = st_ff.byte_out;
	assign lnk.tx_done = st_ff.done;
	assign lnk.tx_busy = st_ff.busy;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_tx_csum;
		st_ff.busy && i_tx_ready && !i_abort && !lnk.tx_start && st_ff.idx == 4'h7
			|=> o_tx_byte == ~lsr_csum_add($past(st_ff.sum), $past(st_ff.byte_out));
	endproperty
	a_tx_csum: assert property (p_tx_csum) else $error("wrong response checksum");
endmodule

/* File: dv/lsr_master_model.sv */
// Bus master model that sends headers and frames and collects the slave responses.
`timescale 1ns/1ps
module lsr_master_model (
	input wire logic i_clk,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_byte,
	output logic o_id_valid,
	output logic [7:0] o_id,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_tx_ready
);
	logic [7:0] got [9];

	// The bus is quiet at time zero.
	initial begin
		o_id_valid = 1'b0;
		o_id = 8'h00;
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_tx_ready = 1'b0;
	end

	// Sends one header byte; once released, the line shows the inverse value.
	task automatic send_id(input logic [7:0] id);
		@(posedge i_clk);
		o_id_valid <= 1'b1;
		o_id <= id;
		@(posedge i_clk);
		o_id_valid <= 1'b0;
		o_id <= ~id;
	endtask

	// Sends one data byte in the same manner.
	task automatic send_byte(input logic [7:0] b);
		@(posedge i_clk);
		o_rx_valid <= 1'b1;
		o_rx_byte <= b;
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx_byte <= ~b;
	endtask

	// Sends a preparing frame and its checksum; bad flips the checksum's low bit.
	task automatic send_frame(input logic [7:0] id, input logic [7:0] d [8], input int n,
		input logic bad);
		logic [8:0] s;
		s = 9'h000;
		send_id(id);
		for (int k = 0; k < n; k++) begin
			send_byte(d[k]);
			s = {1'b0, s[7:0]} + {1'b0, d[k]};
			s = {1'b0, s[7:0]} + {8'h00, s[8]};
		end
		send_byte(~s[7:0] ^ {7'h00, bad});
	endtask

	// Collects nine response bytes; stall leaves ready low on every other cycle.
	task automatic recv(input logic stall, output logic ok);
		int k;
		k = 0;
		for (int t = 0; t < 300 && k < 9; t++) begin
			@(posedge i_clk);
			if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
				got[k] = i_tx_byte;
				k++;
			end
			o_tx_ready <= (k < 9) && (!stall || t[0]);
		end
		ok = (k == 9);
	endtask
endmodule

/* File: dv/lsr_top_tb_top.sv */
// Self-checking testbench of the status readout block.
`timescale 1ns/1ps
module lsr_top_tb_top;
	import lsr_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata, o_tx_byte, rx_byte, id;
	logic o_irq, o_tx_valid, o_flag_clear, id_valid, rx_valid, tx_ready;
	logic end_switch_state = 1'b1;
	logic [15:0] apos = 16'hA53C;
	logic [15:0] tpos = 16'h1E87;
	logic [10:0] spos = 11'h5B6;
	logic [5:0] fl = 6'h2D;
	logic [1:0] tinfo = 2'h2;
	logic [3:0] irun = 4'hC, ihold = 4'h3, vmax = 4'hA, vmin = 4'h5, acc = 4'h9, le = 4'h6;
	logic ashape = 1'b1, shaft = 1'b0, ovx = 1'b1, ovy = 1'b0, cpf = 1'b1;
	logic [1:0] smode = 2'h1;
	logic [2:0] mot = 3'h5;
	logic [6:0] addr = 7'h35;
	logic [4:0] dyn = 5'h0B;
	logic [7:0] ex [9];
	int n_errors = 0;
	int comparisons = 0;
	int n_fc = 0;

	// Clock at 20 ns.
	initial forever #10 i_clk = ~i_clk;

	// Counts flag clear pulses.
	always @(posedge i_clk) begin
		if (o_flag_clear === 1'b1) begin
			n_fc <= n_fc + 1;
		end
	end

	lsr_top lsr_top_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
		.i_id_valid(id_valid), .i_id(id), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
		.o_tx_valid, .o_tx_byte, .i_tx_ready(tx_ready), .o_flag_clear,
		.i_end_switch_state(end_switch_state), .i_actual_position(apos), .i_target_position(tpos),
		.i_secondary_position(spos), .i_supply_reset_flag(fl[5]), .i_step_loss_flag(fl[4]),
		.i_electrical_defect_flag(fl[3]), .i_undervoltage_flag(fl[2]),
		.i_thermal_shutdown_flag(fl[1]), .i_thermal_warning_flag(fl[0]), .i_temp_info(tinfo),
		.i_run_current(irun), .i_hold_current(ihold), .i_max_velocity(vmax),
		.i_min_velocity(vmin), .i_acceleration_shape(ashape), .i_step_resolution(smode),
		.i_shaft(shaft), .i_acceleration(acc), .i_motion(mot), .i_overcurrent_coil_x(ovx),
		.i_overcurrent_coil_y(ovy), .i_charge_pump_failure(cpf), .i_lin_timeout_error(le[3]),
		.i_lin_data_error(le[2]), .i_lin_header_error(le[1]), .i_lin_bit_error(le[0]));

	lsr_master_model lsr_master_model_i (.i_clk, .i_tx_valid(o_tx_valid),
		.i_tx_byte(o_tx_byte), .o_id_valid(id_valid), .o_id(id), .o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte), .o_tx_ready(tx_ready));

	// Compares one value and counts the result.
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Register bus write and checked read.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string nm);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		check(nm, o_rdata, exp);
	endtask

	// Protected identifier of the short preparing frame.
	function automatic logic [7:0] pid(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction

	// Builds the expected response: 0 position, 1 and 2 the status parts.
	task automatic exp_frame(input int kind);
		logic [8:0] s;
		ex = '{default: 8'hFF};
		case (kind)
			0: ex[0:3] = '{{end_switch_state, addr}, apos[15:8], apos[7:0], {fl, tinfo}};
			1: ex[0:6] = '{{1'b1, addr}, {irun, ihold}, {vmax, vmin}, {ashape, smode, shaft, acc},
				{fl, tinfo}, {mot, end_switch_state, ovx, ovy, 1'b1, cpf}, {4'hF, le}};
			default: ex[0:6] = '{{1'b1, addr}, apos[15:8], apos[7:0], tpos[15:8], tpos[7:0],
				spos[7:0], {5'h1F, spos[10:8]}};
		endcase
		s = 9'h000;
		for (int k = 0; k < 8; k++) begin
			s = {1'b0, s[7:0]} + {1'b0, ex[k]};
			s = {1'b0, s[7:0]} + {8'h00, s[8]};
		end
		ex[8] = ~s[7:0];
	endtask

	// Sends a long or short preparing frame.
	task automatic prep(input logic lng, input logic [6:0] cmd, input logic [6:0] a,
		input logic bad);
		logic [7:0] d [8];
		if (lng) begin
			d = '{APP_CMD_BYTE, {1'b1, cmd}, {1'b1, a}, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
			lsr_master_model_i.send_frame(PID_DIAG_REQ, d, 8, bad);
		end else begin
			d = '{{1'b1, cmd}, {1'b1, a}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
			lsr_master_model_i.send_frame(pid({1'b0, dyn}), d, 2, bad);
		end
		repeat (3) @(posedge i_clk);
	endtask

	// Fetches one response and compares all nine bytes.
	task automatic fetch(input int kind, input logic stall, input string nm);
		logic ok;
		exp_frame(kind);
		lsr_master_model_i.send_id(PID_DIAG_RSP);
		lsr_master_model_i.recv(stall, ok);
		check({nm, " complete"}, {7'h00, ok}, 8'h01);
		if (!ok) begin
			report_and_stop();
		end
		for (int k = 0; k < 9; k++) begin
			check(nm, lsr_master_model_i.got[k], ex[k]);
		end
		repeat (3) @(posedge i_clk);
		#1;
		check({nm, " idle"}, {7'h00, o_tx_valid}, 8'h00);
	endtask

	// Reset values, register access and an unmapped index.
	task automatic t_regs();
		rd_chk(REG_NODE_ADDR, 8'h00, "node address reset");
		rd_chk(REG_STATE, 8'h00, "state reset");
		wr(REG_NODE_ADDR, {1'b0, addr});
		wr(REG_DYN_ID, {3'h0, dyn});
		wr(3'h7, 8'hFF);
		rd_chk(REG_NODE_ADDR, {1'b0, addr}, "node address");
		rd_chk(REG_DYN_ID, {3'h0, dyn}, "dynamic id");
		rd_chk(3'h7, 8'h00, "unmapped");
	endtask

	// Long position query answers once and clears no flag.
	task automatic t_pos();
		int fc;
		fc = n_fc;
		prep(1'b1, CMD_POSITION, addr, 1'b0);
		rd_chk(REG_STATE, 8'h02, "position pending");
		fetch(0, 1'b0, "position");
		check("no flag clear", n_fc[7:0], fc[7:0]);
		rd_chk(REG_STATE, 8'h00, "position served");
		rd_chk(REG_IRQ_STAT, 8'h03, "irq status");
		wr(REG_IRQ_STAT, 8'h03);
		rd_chk(REG_IRQ_STAT, 8'h00, "irq cleared");
	endtask

	// Short full status query, both parts, the first with a stalling master.
	task automatic t_full();
		int fc;
		fc = n_fc;
		prep(1'b0, CMD_FULL_STATUS, addr, 1'b0);
		fetch(1, 1'b1, "status one");
		check("flag clear", n_fc[7:0], fc[7:0] + 8'h01);
		rd_chk(REG_STATE, 8'h06, "part two pending");
		fetch(2, 1'b0, "status two");
		rd_chk(REG_STATE, 8'h00, "status served");
	endtask

	// Long full status, second part never asked, then a new query.
	task automatic t_skip();
		@(posedge i_clk);
		apos <= 16'h7F01;
		end_switch_state <= 1'b0;
		prep(1'b1, CMD_FULL_STATUS, addr, 1'b0);
		fetch(1, 1'b0, "long status one");
		prep(1'b0, CMD_POSITION, addr, 1'b0);
		fetch(0, 1'b1, "position after skip");
	endtask

	// Wrong address and bad checksum are refused; interrupt masking.
	task automatic t_refuse();
		logic seen;
		logic [7:0] d [8];
		seen = 1'b0;
		d = '{default: {1'b1, addr}};
		d[0] = {1'b1, CMD_POSITION};
		wr(REG_IRQ_STAT, 8'h07);
		prep(1'b0, CMD_POSITION, addr ^ 7'h01, 1'b0);
		prep(1'b0, 7'h02, addr, 1'b0);
		lsr_master_model_i.send_frame(pid({1'b0, dyn}) ^ 8'h80, d, 2, 1'b0);
		prep(1'b0, CMD_POSITION, addr, 1'b1);
		rd_chk(REG_STATE, 8'h00, "refused frames");
		rd_chk(REG_IRQ_STAT, 8'h04, "checksum error");
		check("irq masked", {7'h00, o_irq}, 8'h00);
		wr(REG_IRQ_MASK, 8'h04);
		rd_chk(REG_IRQ_MASK, 8'h04, "irq mask");
		repeat (2) @(posedge i_clk);
		#1;
		check("irq raised", {7'h00, o_irq}, 8'h01);
		wr(REG_IRQ_STAT, 8'h04);
		repeat (2) @(posedge i_clk);
		#1;
		check("irq dropped", {7'h00, o_irq}, 8'h00);
		lsr_master_model_i.send_id(PID_DIAG_RSP);
		repeat (12) begin
			@(posedge i_clk);
			seen = seen | (o_tx_valid !== 1'b0);
		end
		check("no answer", {7'h00, seen}, 8'h00);
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_pos();
		t_full();
		t_skip();
		t_refuse();
		report_and_stop();
	end
endmodule
